// File: jfpr_pkg.sv
// Package for the programming data registers behind the test access port
// Behaviour
// - Reset chain shifts once per TCK in Shift-DR
// - Code 0x4 selects 16-bit unlock register
// - Shift signature in, compare on Update-DR
// - Programming enabled only while signature matches
// - Unlock register cleared at power-on reset
// - Code 0x5 selects 15-bit command register
// - Capture-DR loads previous command result
// - Shift-DR outputs result, takes new command
// - Update-DR presents command to flash inputs
// - Run-Test/Idle after update executes one cycle
// - Code 0x6 selects 1024-bit page fill chain
// - Each completed byte goes to page buffer
// - Code 0x7 selects 1032-bit page dump chain
// - Dump fetches bytes in Shift-DR, ignores TDI
// - Reset bit holds reset, then time-out
// - Reset bit acts at once, not latched
// - All shift registers move LSB first
// - Code 0xC selects one-bit reset register
// - Instruction register is four bits wide
package jfpr_pkg;
  // ==========================================================
  // Instructions
  localparam int INSTR_W = 4;
  localparam logic [3:0] PROGRAM_UNLOCK_INSTR = 4'h4;
  localparam logic [3:0] PROGRAM_COMMAND_INSTR = 4'h5;
  localparam logic [3:0] PAGE_FILL_INSTR = 4'h6;
  localparam logic [3:0] PAGE_DUMP_INSTR = 4'h7;
  localparam logic [3:0] CHIP_RESET_INSTR = 4'hC;

  // ==========================================================
  // Data register geometry
  localparam int UNLOCK_W = 16;
  localparam int CMD_W = 15;
  localparam int PAGE_BITS = 1024;
  localparam int DUMP_BITS = 1032;
  localparam int BYTE_W = 8;
  localparam int PAGE_BYTES = PAGE_BITS / BYTE_W;
  localparam int PAGE_ADDR_W = $clog2(PAGE_BYTES);
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam logic [14:0] CMD_RESET = 15'h0000;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_TIMEOUT_US = 64;
  localparam int RESET_TIMEOUT_CYC = (RESET_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic run_idle;
  } jfpr_tap_t;

  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic exec;
  } jfpr_flash_cmd_t;

  typedef struct packed {
    logic we;
    logic [PAGE_ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } jfpr_page_wr_t;
endpackage

// File: jfpr_sync.sv
// Two-stage synchroniser for independent single-bit levels and toggles
`timescale 1ns/1ps
`default_nettype none
module jfpr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = en ? d : meta;
    next_q = en ? meta : q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// File: jfpr_regs.sv
// Programming data registers: scan side on TCK, chip side on clk
`timescale 1ns/1ps
`default_nettype none
module jfpr_regs #(
  parameter int RESET_TIMEOUT = jfpr_pkg::RESET_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire jfpr_pkg::jfpr_tap_t tap,
  input wire logic [jfpr_pkg::INSTR_W-1:0] ir,
  input wire logic tdi,
  output logic tdo,
  output logic chip_reset,
  output logic prog_mode,
  output jfpr_pkg::jfpr_flash_cmd_t flash_cmd,
  input wire logic [jfpr_pkg::CMD_W-1:0] cmd_result,
  output jfpr_pkg::jfpr_page_wr_t page_wr,
  output logic [jfpr_pkg::PAGE_ADDR_W-1:0] page_rd_addr,
  input wire logic [jfpr_pkg::BYTE_W-1:0] page_rd_data
);
  import jfpr_pkg::*;

  // ==========================================================
  // Scan side state (TCK domain)
  logic rst_bit, next_rst_bit;
  logic bypass_bit, next_bypass_bit;
  logic [UNLOCK_W-1:0] unlock_sr, next_unlock_sr;
  logic prog_ok, next_prog_ok;
  logic [CMD_W-1:0] cmd_sr, next_cmd_sr;
  logic [CMD_W-1:0] cmd_hold, next_cmd_hold;
  logic cmd_tog, next_cmd_tog;
  logic exec_armed, next_exec_armed;
  logic exec_tog, next_exec_tog;
  logic [BYTE_W-1:0] pg_sr, next_pg_sr;
  logic [2:0] pg_bit, next_pg_bit;
  logic [PAGE_ADDR_W-1:0] fill_addr, next_fill_addr;
  logic [PAGE_ADDR_W-1:0] next_page_rd_addr;
  jfpr_page_wr_t next_page_wr;
  logic [CMD_W-1:0] res_tck, next_res_tck;
  logic res_ack, next_res_ack;
  logic res_req_t;
  logic next_tdo;

  // Chip side state (clk domain)
  logic [CMD_W-1:0] res_hold, next_res_hold;
  logic res_req, next_res_req;
  logic res_ack_c;
  logic rst_c, prog_c, cmd_tog_c, exec_tog_c;
  logic cmd_tog_d, next_cmd_tog_d;
  logic exec_tog_d, next_exec_tog_d;
  logic [$clog2(RESET_TIMEOUT+1)-1:0] hold_cnt, next_hold_cnt;
  logic next_chip_reset;
  logic next_prog_mode;
  jfpr_flash_cmd_t next_flash_cmd;

  localparam logic [$clog2(RESET_TIMEOUT+1)-1:0] HOLD_LOAD =
    ($clog2(RESET_TIMEOUT+1))'(RESET_TIMEOUT);

  // One LSB-first step of the internal byte register, shared by fill and dump
  function automatic logic [BYTE_W-1:0] byte_step(
    input logic [BYTE_W-1:0] sr,
    input logic bit_in
  );
    return {bit_in, sr[BYTE_W-1:1]};
  endfunction

  // ==========================================================
  // Crossings
  jfpr_sync #(.W(5)) u_to_clk (
    .clk(clk),
    .rstn(rstn),
    .en(ce),
    .d({rst_bit, prog_ok, cmd_tog, exec_tog, res_ack}),
    .q({rst_c, prog_c, cmd_tog_c, exec_tog_c, res_ack_c})
  );

  // Enable tied high: the chip clock enable does not freeze the scan side
  jfpr_sync #(.W(1)) u_to_tck (
    .clk(tck),
    .rstn(rstn),
    .en(1'b1),
    .d(res_req),
    .q(res_req_t)
  );

  // ==========================================================
  // Scan side next state
  always_comb begin
    next_rst_bit = rst_bit;
    next_bypass_bit = bypass_bit;
    next_unlock_sr = unlock_sr;
    next_prog_ok = prog_ok;
    next_cmd_sr = cmd_sr;
    next_cmd_hold = cmd_hold;
    next_cmd_tog = cmd_tog;
    next_exec_armed = exec_armed;
    next_exec_tog = exec_tog;
    next_pg_sr = pg_sr;
    next_pg_bit = pg_bit;
    next_fill_addr = fill_addr;
    next_page_rd_addr = page_rd_addr;
    next_page_wr = page_wr;
    next_page_wr.we = 1'b0;
    next_res_tck = res_tck;
    next_res_ack = res_ack;
    // Result word is stable while request and ack differ
    if (res_req_t != res_ack) begin
      next_res_tck = res_hold;
      next_res_ack = res_req_t;
    end
    // One internal cycle per idle entry after a command update
    // Decided before the decode, so an update in the same cycle still re-arms
    if (exec_armed && tap.run_idle) begin
      next_exec_tog = ~exec_tog;
      next_exec_armed = 1'b0;
    end
    case (ir)
      CHIP_RESET_INSTR: begin
        // Not latched: the shifted value acts on reset directly
        if (tap.shift_dr) begin
          next_rst_bit = tdi;
        end
      end
      PROGRAM_UNLOCK_INSTR: begin
        if (tap.shift_dr) begin
          next_unlock_sr = {tdi, unlock_sr[UNLOCK_W-1:1]};
        end
        if (tap.update_dr) begin
          // Compared at update only, so a half-shifted signature never unlocks
          next_prog_ok = (unlock_sr == UNLOCK_SIGNATURE);
        end
      end
      PROGRAM_COMMAND_INSTR: begin
        if (tap.capture_dr) begin
          next_cmd_sr = res_tck;
        end else if (tap.shift_dr) begin
          next_cmd_sr = {tdi, cmd_sr[CMD_W-1:1]};
        end
        if (tap.update_dr) begin
          // Word stays put while its toggle crosses, so it needs no gray code
          next_cmd_hold = cmd_sr;
          next_cmd_tog = ~cmd_tog;
          next_exec_armed = 1'b1;
        end
      end
      PAGE_FILL_INSTR: begin
        if (tap.capture_dr) begin
          next_pg_bit = 3'h0;
          next_fill_addr = '0;
        end else if (tap.shift_dr) begin
          next_pg_sr = byte_step(pg_sr, tdi);
          next_pg_bit = pg_bit + 3'h1;
          if (pg_bit == LAST_BIT) begin
            next_page_wr.we = 1'b1;
            next_page_wr.addr = fill_addr;
            next_page_wr.data = byte_step(pg_sr, tdi);
            // Wraps to zero past the last byte of a page
            next_fill_addr = fill_addr + 1'b1;
          end
        end
      end
      PAGE_DUMP_INSTR: begin
        // Capture only rewinds; the first byte out is filler
        if (tap.capture_dr) begin
          next_pg_sr = 8'h00;
          next_pg_bit = 3'h0;
          next_page_rd_addr = '0;
        end else if (tap.shift_dr) begin
          next_pg_bit = pg_bit + 3'h1;
          if (pg_bit == LAST_BIT) begin
            next_pg_sr = page_rd_data;
            next_page_rd_addr = page_rd_addr + 1'b1;
          end else begin
            next_pg_sr = byte_step(pg_sr, 1'b0);
          end
        end
      end
      default: begin
        if (tap.capture_dr) begin
          next_bypass_bit = 1'b0;
        end else if (tap.shift_dr) begin
          next_bypass_bit = tdi;
        end
      end
    endcase
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      rst_bit <= 1'b0;
      bypass_bit <= 1'b0;
      unlock_sr <= UNLOCK_RESET;
      prog_ok <= 1'b0;
      cmd_sr <= CMD_RESET;
      cmd_hold <= CMD_RESET;
      cmd_tog <= 1'b0;
      exec_armed <= 1'b0;
      exec_tog <= 1'b0;
      pg_sr <= 8'h00;
      pg_bit <= 3'h0;
      fill_addr <= '0;
      page_rd_addr <= '0;
      page_wr <= '0;
      res_tck <= CMD_RESET;
      res_ack <= 1'b0;
    end else begin
      rst_bit <= next_rst_bit;
      bypass_bit <= next_bypass_bit;
      unlock_sr <= next_unlock_sr;
      prog_ok <= next_prog_ok;
      cmd_sr <= next_cmd_sr;
      cmd_hold <= next_cmd_hold;
      cmd_tog <= next_cmd_tog;
      exec_armed <= next_exec_armed;
      exec_tog <= next_exec_tog;
      pg_sr <= next_pg_sr;
      pg_bit <= next_pg_bit;
      fill_addr <= next_fill_addr;
      page_rd_addr <= next_page_rd_addr;
      page_wr <= next_page_wr;
      res_tck <= next_res_tck;
      res_ack <= next_res_ack;
    end
  end

  // ==========================================================
  // TDO, launched on the falling edge so the host samples it on the rise
  always_comb begin
    case (ir)
      CHIP_RESET_INSTR: next_tdo = rst_bit;
      PROGRAM_UNLOCK_INSTR: next_tdo = unlock_sr[0];
      PROGRAM_COMMAND_INSTR: next_tdo = cmd_sr[0];
      PAGE_FILL_INSTR: next_tdo = pg_sr[0];
      PAGE_DUMP_INSTR: next_tdo = pg_sr[0];
      default: next_tdo = bypass_bit;
    endcase
  end

  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      tdo <= 1'b0;
    end else begin
      tdo <= next_tdo;
    end
  end

  // ==========================================================
  // Chip side next state
  always_comb begin
    next_res_hold = res_hold;
    next_res_req = res_req;
    next_cmd_tog_d = cmd_tog_c;
    next_exec_tog_d = exec_tog_c;
    next_flash_cmd = flash_cmd;
    next_flash_cmd.exec = 1'b0;
    next_prog_mode = prog_c;
    next_hold_cnt = hold_cnt;
    next_chip_reset = 1'b0;
    // New result only once the scan side has taken the last one
    if (res_ack_c == res_req && cmd_result != res_hold) begin
      next_res_hold = cmd_result;
      next_res_req = ~res_req;
    end
    if (cmd_tog_c != cmd_tog_d) begin
      next_flash_cmd.cmd = cmd_hold;
    end
    if (exec_tog_c != exec_tog_d) begin
      next_flash_cmd.exec = 1'b1;
    end
    // Time-out restarts for as long as the reset bit stays high
    if (rst_c) begin
      next_hold_cnt = HOLD_LOAD;
      next_chip_reset = 1'b1;
    end else if (hold_cnt != '0) begin
      next_hold_cnt = hold_cnt - 1'b1;
      next_chip_reset = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_hold <= CMD_RESET;
      res_req <= 1'b0;
      cmd_tog_d <= 1'b0;
      exec_tog_d <= 1'b0;
      flash_cmd <= '0;
      prog_mode <= 1'b0;
      hold_cnt <= '0;
      chip_reset <= 1'b0;
    end else if (ce) begin
      res_hold <= next_res_hold;
      res_req <= next_res_req;
      cmd_tog_d <= next_cmd_tog_d;
      exec_tog_d <= next_exec_tog_d;
      flash_cmd <= next_flash_cmd;
      prog_mode <= next_prog_mode;
      hold_cnt <= next_hold_cnt;
      chip_reset <= next_chip_reset;
    end
  end
endmodule
`default_nettype wire

// File: jfpr_regs_monitor.sv
// Checker for the programming data registers
`timescale 1ns/1ps
`default_nettype none
module jfpr_regs_monitor
  import jfpr_pkg::*;
#(
  parameter int RESET_TIMEOUT = RESET_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire jfpr_pkg::jfpr_tap_t tap,
  input wire logic [jfpr_pkg::INSTR_W-1:0] ir,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic chip_reset,
  input wire logic prog_mode,
  input wire jfpr_pkg::jfpr_flash_cmd_t flash_cmd,
  input wire logic [jfpr_pkg::CMD_W-1:0] cmd_result,
  input wire jfpr_pkg::jfpr_page_wr_t page_wr,
  input wire logic [jfpr_pkg::PAGE_ADDR_W-1:0] page_rd_addr,
  input wire logic [jfpr_pkg::BYTE_W-1:0] page_rd_data
);
  // ====
  // Helpers
  int hi_cnt;
  logic [PAGE_ADDR_W-1:0] last_addr;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hi_cnt <= 0;
    else hi_cnt <= chip_reset ? hi_cnt + 1 : 0;
  end
  // Address of the byte last handed to the page buffer
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) last_addr <= '0;
    else if (page_wr.we) last_addr <= page_wr.addr;
  end
  sequence s_we_pulse;
    page_wr.we ##1 !page_wr.we;
  endsequence
  sequence s_exec_pulse;
    flash_cmd.exec ##1 !flash_cmd.exec;
  endsequence
  // ====
  // Properties
  we_one_tck_a: assert property (@(posedge tck) disable iff (!rstn)
    page_wr.we |-> s_we_pulse) else $error("page write strobe too long");
  fill_only_a: assert property (@(posedge tck) disable iff (!rstn)
    $rose(page_wr.we) |-> $past(ir) == PAGE_FILL_INSTR) else $error("write outside fill");
  addr_step_a: assert property (@(posedge tck) disable iff (!rstn)
    page_wr.we && page_wr.addr != 0 |-> page_wr.addr == last_addr + 7'h1)
    else $error("page write address skipped");
  rd_step_a: assert property (@(posedge tck) disable iff (!rstn)
    page_rd_addr != $past(page_rd_addr) && page_rd_addr != 0
    |-> page_rd_addr == $past(page_rd_addr) + 7'h1 && $past(tap.shift_dr))
    else $error("read address step wrong");
  exec_once_a: assert property (@(posedge clk) disable iff (!rstn)
    flash_cmd.exec |-> s_exec_pulse) else $error("exec longer than one clock");
  exec_stable_a: assert property (@(posedge clk) disable iff (!rstn)
    flash_cmd.exec |-> $stable(flash_cmd.cmd)) else $error("command moved at exec");
  unlock_ir_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(prog_mode) |-> ir == PROGRAM_UNLOCK_INSTR) else $error("mode changed by wrong ir");
  reset_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> !prog_mode && !chip_reset) else $error("outputs not clear after reset");
  reset_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(chip_reset) |-> hi_cnt >= RESET_TIMEOUT) else $error("chip reset too short");
  ce_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(chip_reset) && $stable(prog_mode) && $stable(flash_cmd))
    else $error("chip side moved while frozen");
endmodule
bind jfpr_regs jfpr_regs_monitor #(.RESET_TIMEOUT(RESET_TIMEOUT)) jfpr_regs_monitor_inst (
  .clk, .rstn, .ce, .tck, .tap, .ir, .tdi, .tdo, .chip_reset, .prog_mode, .flash_cmd,
  .cmd_result, .page_wr, .page_rd_addr, .page_rd_data);
`default_nettype wire

// File: jfpr_flash_model.sv
// Flash side stand-in: command executor and page buffer
`timescale 1ns/1ps
`default_nettype none
module jfpr_flash_model
  import jfpr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tck,
  input wire jfpr_pkg::jfpr_flash_cmd_t flash_cmd,
  output logic [jfpr_pkg::CMD_W-1:0] cmd_result,
  input wire jfpr_pkg::jfpr_page_wr_t page_wr,
  input wire logic [jfpr_pkg::PAGE_ADDR_W-1:0] page_rd_addr,
  output logic [jfpr_pkg::BYTE_W-1:0] page_rd_data
);
  // ====
  // Storage
  logic [BYTE_W-1:0] mem [0:PAGE_BYTES-1];
  // Result is the inverted command so a stale capture is visible
  always @(posedge clk or negedge rstn) begin
    if (!rstn) cmd_result <= '0;
    else if (flash_cmd.exec) cmd_result <= ~flash_cmd.cmd;
  end
  always @(posedge tck) begin
    if (page_wr.we) mem[page_wr.addr] <= page_wr.data;
  end
  assign page_rd_data = mem[page_rd_addr];
endmodule
`default_nettype wire

// File: jfpr_regs_tb_top.sv
// Bench for the programming data registers
`timescale 1ns/1ps
`default_nettype none
module jfpr_regs_tb_top;
  import jfpr_pkg::*;
  localparam int RT = 8;
  logic clk, rstn, ce, tck, tck_en, tdi, tdo, chip_reset, prog_mode;
  jfpr_tap_t tap;
  logic [3:0] ir;
  jfpr_flash_cmd_t flash_cmd;
  jfpr_page_wr_t page_wr;
  logic [CMD_W-1:0] cmd_result, exp_res, c;
  logic [PAGE_ADDR_W-1:0] page_rd_addr;
  logic [BYTE_W-1:0] page_rd_data;
  logic [1031:0] din, dout;
  logic [15:0] seed;
  int err_total, check_count, exec_cnt, we_cnt;
  logic [7:0] page_q [$];
  jfpr_regs #(.RESET_TIMEOUT(RT)) jfpr_regs_inst (.clk, .rstn, .ce, .tck, .tap, .ir,
    .tdi, .tdo, .chip_reset, .prog_mode, .flash_cmd, .cmd_result, .page_wr, .page_rd_addr,
    .page_rd_data);
  jfpr_flash_model jfpr_flash_model_inst (.clk, .rstn, .tck, .flash_cmd, .cmd_result,
    .page_wr, .page_rd_addr, .page_rd_data);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Link clock stands still between frames
  initial begin
    tck = 0;
    #1.3;
    forever #3 tck = tck_en ? ~tck : 1'b0;
  end
  // Counted on the opposite edge, where the registered strobes stand settled
  always @(negedge clk) if (flash_cmd.exec === 1'b1) exec_cnt++;
  always @(negedge tck) if (page_wr.we === 1'b1) we_cnt++;
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  task automatic check(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tstep(input jfpr_tap_t t);
    tap = t;
    tdi = 1'b0;
    @(posedge tck);
    #1;
  endtask
  // Idle edges first let the scan side take a fresh command result
  task automatic scan(input logic [3:0] code, input int n, input bit ri);
    ir = code;
    tck_en = 1;
    repeat (8) tstep(4'h0);
    tstep(4'h8);
    for (int i = 0; i < n; i++) begin
      tap = 4'h4;
      tdi = din[i];
      @(posedge tck);
      dout[i] = tdo;
      #1;
    end
    tstep(4'h2);
    tstep(4'h0);
    if (ri) begin
      tck_en = 0;
      wclk(5);
      tck_en = 1;
      tstep(4'h1);
    end
    repeat (2) tstep(4'h0);
    tck_en = 0;
  endtask
  initial begin
    rstn = 0;
    ce = 1;
    tap = '0;
    ir = '0;
    tdi = 0;
    tck_en = 1;
    seed = 16'h2374;
    din = '0;
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    tck_en = 0;
    check("out_a", {tdo, chip_reset, prog_mode, page_rd_addr}, 32'h0);
    check("out_b", {flash_cmd, page_wr}, 32'h0);
    din[0] = 1'b1;
    scan(CHIP_RESET_INSTR, 1, 0);
    wclk(5);
    check("chip_reset", chip_reset, 32'h1);
    $display("Test reset_on done");
    din[15:0] = {rnd(), rnd()} | 16'h0001;
    scan(PROGRAM_UNLOCK_INSTR, 16, 0);
    wclk(6);
    check("prog_bad", prog_mode, 32'h0);
    din[15:0] = UNLOCK_SIGNATURE;
    scan(PROGRAM_UNLOCK_INSTR, 16, 0);
    wclk(6);
    check("prog_ok", prog_mode, 32'h1);
    $display("Test unlock done");
    exp_res = '0;
    for (int k = 0; k < 3; k++) begin
      din[15:0] = {rnd(), rnd()};
      c = din[14:0];
      scan(PROGRAM_COMMAND_INSTR, 15, k != 1);
      wclk(6);
      check("cmd_out", dout[14:0], exp_res);
      check("cmd", flash_cmd.cmd, c);
      if (k != 1) exp_res = ~c;
    end
    check("exec_cnt", exec_cnt, 32'h2);
    $display("Test command done");
    for (int k = 0; k < 1024; k += 8) begin
      din[k +: 8] = rnd();
      page_q.push_back(din[k +: 8]);
    end
    // Lone device on the chain, so the page chains may be used
    scan(PAGE_FILL_INSTR, 1024, 0);
    check("we_cnt", we_cnt, 32'h80);
    for (int k = 0; k < 1032; k += 8) din[k +: 8] = rnd();
    scan(PAGE_DUMP_INSTR, 1032, 0);
    check("filler", dout[7:0], 32'h0);
    for (int k = 0; k < 128; k++) check("page", dout[8 + 8 * k +: 8], page_q[k]);
    $display("Test page done");
    // Chip side frozen: the cleared signature must not reach the mode yet
    ce = 1'b0;
    din[15:0] = 16'h0000;
    scan(PROGRAM_UNLOCK_INSTR, 16, 0);
    wclk(6);
    check("prog_frozen", prog_mode, 32'h1);
    ce = 1'b1;
    wclk(6);
    check("prog_off", prog_mode, 32'h0);
    $display("Test freeze done");
    din[0] = 1'b1;
    scan(4'hF, 2, 0);
    check("bypass", dout[1:0], 32'h2);
    $display("Test bypass done");
    din[0] = 1'b0;
    scan(CHIP_RESET_INSTR, 1, 0);
    wclk(RT);
    check("reset_hold", chip_reset, 32'h1);
    wclk(8);
    check("reset_end", chip_reset, 32'h0);
    $display("Test reset_off done");
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
